// ### rtl/tpc_pkg.sv
// Package for the 16-bit timer with polarity-controlled input and output.
// Assumes a 32-bit Avalon-MM register bus on a byte address.
package tpc_pkg;

  // ==========================================================================
  // Register map (byte addresses = 4 * index).
  // ==========================================================================
  localparam logic [11:0] TPC_IDX_COUNT_HIGH = 12'hF00;
  localparam logic [11:0] TPC_IDX_COUNT_LOW  = 12'hF01;
  localparam logic [11:0] TPC_IDX_RELOAD_H   = 12'hF02;
  localparam logic [11:0] TPC_IDX_RELOAD_L   = 12'hF03;
  localparam logic [11:0] TPC_IDX_PWM_H      = 12'hF04;
  localparam logic [11:0] TPC_IDX_PWM_L      = 12'hF05;
  localparam logic [11:0] TPC_IDX_CONTROL    = 12'hF06;
  localparam logic [11:0] TPC_IDX_STATUS     = 12'hF07;
  localparam int          TPC_ADDR_W         = 14;

  // ==========================================================================
  // Reset values and the count restart value.
  // ==========================================================================
  localparam logic [7:0]  TPC_RST_COUNT_HIGH = 8'h00;
  localparam logic [7:0]  TPC_RST_COUNT_LOW  = 8'h01;
  localparam logic [15:0] TPC_RST_RELOAD     = 16'hFFFF;
  localparam logic [15:0] TPC_RST_PWM        = 16'h0000;
  localparam logic [15:0] TPC_COUNT_START    = 16'h0001;

  // ==========================================================================
  // Control and status register fields.
  // ==========================================================================
  localparam int TPC_CTL_ENABLE = 7;
  localparam int TPC_CTL_POL    = 6;
  localparam int TPC_CTL_MODE_H = 2;
  localparam int TPC_CTL_MODE_L = 0;
  localparam int TPC_STS_OUT    = 0;
  localparam int TPC_STS_ARMED  = 1;

  typedef enum logic [2:0] {
    TPC_MODE_ONESHOT = 3'h0,
    TPC_MODE_CONT    = 3'h1,
    TPC_MODE_COUNTER = 3'h2,
    TPC_MODE_PWM     = 3'h3,
    TPC_MODE_CAPTURE = 3'h4,
    TPC_MODE_COMPARE = 3'h5,
    TPC_MODE_GATED   = 3'h6,
    TPC_MODE_CAPCMP  = 3'h7
  } tpc_mode_e;

endpackage : tpc_pkg

// ### rtl/tpc_edge_sync.sv
// Two-flop synchroniser with polarity-selected edge detection.
// Assumes the input pin is asynchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
module tpc_edge_sync (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  input  wire logic pol_i,
  output logic      level_o,
  output logic      act_edge_o,
  output logic      inact_edge_o
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else if (ce_i) begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Active edge is rising for polarity 0 and falling for polarity 1.
  assign level_o      = sync_reg;
  assign act_edge_o   = pol_i ? (prev_reg & ~sync_reg)
                              : (~prev_reg & sync_reg);
  assign inact_edge_o = pol_i ? (~prev_reg & sync_reg)
                              : (prev_reg & ~sync_reg);
endmodule : tpc_edge_sync
`default_nettype wire

// ### rtl/tpc_timer.sv
// 16-bit timer/counter with eight modes, polarity control and an
// Avalon-MM register slave. Assumes one clock, mclk_i, and that the
// timer input pin is asynchronous to it.
`timescale 1ns/1ps
`default_nettype none
module tpc_timer
  import tpc_pkg::*;
(
  input  wire logic                        mclk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        ce_i,
  input  wire logic [tpc_pkg::TPC_ADDR_W-1:0] avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [31:0]                 avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic [31:0]                      avs_readdata_o,
  output logic                             avs_waitrequest_o,
  input  wire logic                        timer_input_i,
  output logic                             timer_output_pin_o,
  output logic                             timer_irq_o
);
  import tpc_pkg::*;

  // ==========================================================================
  // Registers and input edges.
  // ==========================================================================
  logic [7:0]  count_high_field_reg;
  logic [7:0]  count_low_field_reg;
  logic [15:0] reload_reg;
  logic [15:0] pwm_reg;
  logic        timer_enable_bit_reg;
  logic        io_polarity_bit_reg;
  tpc_mode_e   mode_reg;
  logic        out_reg;
  logic        armed_reg;
  logic        irq_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;

  logic        in_level;
  logic        in_act;
  logic        in_inact;

  tpc_edge_sync u_sync (
    .mclk_i       (mclk_i),
    .rstn_i       (rstn_i),
    .ce_i         (ce_i),
    .pin_i        (timer_input_i),
    .pol_i        (io_polarity_bit_reg),
    .level_o      (in_level),
    .act_edge_o   (in_act),
    .inact_edge_o (in_inact)
  );

  // ==========================================================================
  // Bus decode. Each access waits one cycle so read data comes from flops.
  // ==========================================================================
  logic [11:0] idx;
  logic        req;
  logic        wr_go;
  logic        rd_go;

  assign idx   = avs_address_i[TPC_ADDR_W-1:2];
  assign req   = avs_read_i | avs_write_i;
  assign wr_go = avs_write_i & ~ack_reg & ce_i & avs_byteenable_i[0];
  assign rd_go = avs_read_i & ~ack_reg & ce_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign avs_readdata_o    = rdata_reg;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= req & ~ack_reg;
    end
  end

  logic [7:0] status_byte;
  assign status_byte = {6'h00, armed_reg, out_reg};

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_go) begin
      unique case (idx)
        TPC_IDX_COUNT_HIGH: rdata_reg <= {24'h0, count_high_field_reg};
        TPC_IDX_COUNT_LOW:  rdata_reg <= {24'h0, count_low_field_reg};
        TPC_IDX_RELOAD_H:   rdata_reg <= {24'h0, reload_reg[15:8]};
        TPC_IDX_RELOAD_L:   rdata_reg <= {24'h0, reload_reg[7:0]};
        TPC_IDX_PWM_H:      rdata_reg <= {24'h0, pwm_reg[15:8]};
        TPC_IDX_PWM_L:      rdata_reg <= {24'h0, pwm_reg[7:0]};
        TPC_IDX_CONTROL:    rdata_reg <= {24'h0, timer_enable_bit_reg,
                                          io_polarity_bit_reg, 3'h0,
                                          mode_reg};
        TPC_IDX_STATUS:     rdata_reg <= {24'h0, status_byte};
        default:            rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Configuration registers.
  // ==========================================================================
  logic wr_ctl;
  logic one_shot_done;
  assign wr_ctl = wr_go & (idx == TPC_IDX_CONTROL);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reload_reg           <= TPC_RST_RELOAD;
      pwm_reg              <= TPC_RST_PWM;
      timer_enable_bit_reg <= 1'b0;
      io_polarity_bit_reg  <= 1'b0;
      mode_reg             <= TPC_MODE_ONESHOT;
    end else begin
      // The one-shot stop must not be lost under a write to another
      // register; a control write in the same cycle still wins.
      if (ce_i && timer_enable_bit_reg && one_shot_done) begin
        timer_enable_bit_reg <= 1'b0;
      end
      if (wr_go && idx == TPC_IDX_RELOAD_H) begin
        reload_reg[15:8] <= avs_writedata_i[7:0];
      end
      if (wr_go && idx == TPC_IDX_RELOAD_L) begin
        reload_reg[7:0] <= avs_writedata_i[7:0];
      end
      if (wr_go && idx == TPC_IDX_PWM_H) begin
        pwm_reg[15:8] <= avs_writedata_i[7:0];
      end
      if (wr_go && idx == TPC_IDX_PWM_L) begin
        pwm_reg[7:0] <= avs_writedata_i[7:0];
      end
      if (wr_ctl) begin
        timer_enable_bit_reg <= avs_writedata_i[TPC_CTL_ENABLE];
        io_polarity_bit_reg  <= avs_writedata_i[TPC_CTL_POL];
        mode_reg <= tpc_mode_e'(avs_writedata_i[TPC_CTL_MODE_H:
                                                 TPC_CTL_MODE_L]);
      end
    end
  end

  // ==========================================================================
  // Counter core.
  // ==========================================================================
  logic [15:0] count;
  logic        at_reload;
  logic        pwm_match;
  logic        tick;
  logic        capture;
  logic        gate_end;

  assign count     = {count_high_field_reg, count_low_field_reg};
  assign at_reload = (count == reload_reg);
  assign pwm_match = (count == pwm_reg);

  // Count enable per mode; input-driven modes use the synchronised pin.
  always_comb begin
    tick    = 1'b0;
    capture = 1'b0;
    unique case (mode_reg)
      TPC_MODE_COUNTER: tick = in_act;
      TPC_MODE_CAPTURE: begin
        tick    = 1'b1;
        capture = in_act;
      end
      TPC_MODE_GATED:   tick = in_level ^ io_polarity_bit_reg;
      TPC_MODE_CAPCMP:  begin
        tick    = armed_reg;
        capture = armed_reg & in_act;
      end
      default:          tick = 1'b1;
    endcase
    tick    = tick & timer_enable_bit_reg;
    capture = capture & timer_enable_bit_reg;
  end

  assign gate_end = timer_enable_bit_reg & (mode_reg == TPC_MODE_GATED)
                    & in_inact;
  assign one_shot_done = (mode_reg == TPC_MODE_ONESHOT) & tick & at_reload;

  logic [15:0] count_next;
  always_comb begin
    count_next = count;
    if (capture || (tick && at_reload)) begin
      count_next = TPC_COUNT_START;
    end else if (tick) begin
      count_next = count + 16'h0001;
    end
  end

  // Software byte writes take priority over the running count.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_high_field_reg <= TPC_RST_COUNT_HIGH;
      count_low_field_reg  <= TPC_RST_COUNT_LOW;
    end else if (ce_i) begin
      count_high_field_reg <= count_next[15:8];
      count_low_field_reg  <= count_next[7:0];
      if (wr_go && idx == TPC_IDX_COUNT_HIGH) begin
        count_high_field_reg <= avs_writedata_i[7:0];
      end
      if (wr_go && idx == TPC_IDX_COUNT_LOW) begin
        count_low_field_reg <= avs_writedata_i[7:0];
      end
    end
  end

  // Capture/compare waits for its first active edge before counting.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      armed_reg <= 1'b0;
    end else if (ce_i) begin
      if (!timer_enable_bit_reg || mode_reg != TPC_MODE_CAPCMP) begin
        armed_reg <= 1'b0;
      end else if (in_act) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Output pin. While disabled it mirrors polarity; once enabled only
  // reload and match events move it, so a polarity write is not seen until
  // the timer is stopped, except in PWM mode where the next reload or match uses it.
  // ==========================================================================
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_reg <= 1'b0;
    end else if (ce_i) begin
      if (!timer_enable_bit_reg) begin
        out_reg <= io_polarity_bit_reg;
      end else if (mode_reg == TPC_MODE_PWM) begin
        if (tick && at_reload) begin
          out_reg <= io_polarity_bit_reg;
        end else if (tick && pwm_match) begin
          out_reg <= ~io_polarity_bit_reg;
        end
      end else if (tick && at_reload) begin
        out_reg <= ~out_reg;
      end
    end
  end

  assign timer_output_pin_o = out_reg;

  // ==========================================================================
  // Interrupt request pulse.
  // ==========================================================================
  logic irq_event;
  assign irq_event = capture | gate_end |
                     (tick & at_reload & (mode_reg != TPC_MODE_GATED));

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      irq_reg <= irq_event & ~irq_reg;
    end else begin
      irq_reg <= 1'b0;
    end
  end

  assign timer_irq_o = irq_reg;
endmodule : tpc_timer
`default_nettype wire

// ### verification/tpc_sva.sv
// Checker for the timer ports: bus wait states, pin and interrupt.
// Bound into tpc_timer; follows the control byte from accepted writes.
`timescale 1ns/1ps
`default_nettype none
module tpc_sva
  import tpc_pkg::*;
(
  input wire logic                           mclk_i,
  input wire logic                           rstn_i,
  input wire logic                           ce_i,
  input wire logic [tpc_pkg::TPC_ADDR_W-1:0] avs_address_i,
  input wire logic                           avs_read_i,
  input wire logic                           avs_write_i,
  input wire logic [31:0]                    avs_writedata_i,
  input wire logic [3:0]                     avs_byteenable_i,
  input wire logic [31:0]                    avs_readdata_o,
  input wire logic                           avs_waitrequest_o,
  input wire logic                           timer_input_i,
  input wire logic                           timer_output_pin_o,
  input wire logic                           timer_irq_o
);
  // ==========================================================================
  // Control shadow
  // ==========================================================================
  // The age counter lets pin relations wait out the write-to-pin latency.
  logic [7:0] sh_reg;
  logic [1:0] age_reg;
  logic       wr_ctl;
  assign wr_ctl = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                  && avs_address_i[13:2] == TPC_IDX_CONTROL;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sh_reg  <= 8'h00;
      age_reg <= 2'h0;
    end else if (wr_ctl) begin
      sh_reg  <= avs_writedata_i[7:0];
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  property p_irq_pulse; timer_irq_o |=> !timer_irq_o; endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("irq pulse longer than one clock");
  property p_wait_one;
    (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i
      |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("more than one wait state");
  property p_rdata_hold; !avs_read_i |=> $stable(avs_readdata_o); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_rdata_upper;
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper)
    else $error("upper read data not zero");
  property p_dis_pol;
    !sh_reg[7] && age_reg == 2'h3
      && sh_reg[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h5}
      |-> timer_output_pin_o == sh_reg[6];
  endproperty
  a_dis_pol: assert property (p_dis_pol)
    else $error("disabled pin differs from polarity");
  property p_run_pol;
    wr_ctl && sh_reg[7] && sh_reg[1:0] == 2'h1 && avs_writedata_i[7]
      && avs_writedata_i[1:0] == 2'h1
      |=> ($stable(timer_output_pin_o) || timer_irq_o) [*2];
  endproperty
  a_run_pol: assert property (p_run_pol)
    else $error("polarity write moved a running pin");
  property p_irq_en; timer_irq_o |-> sh_reg[7] || age_reg != 2'h3; endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("irq while timer disabled");
  property p_cont;
    sh_reg[7] && sh_reg[1:0] == 2'h1 && age_reg == 2'h3
      |-> timer_irq_o == $changed(timer_output_pin_o);
  endproperty
  a_cont: assert property (p_cont)
    else $error("pin toggle and reload disagree");
endmodule : tpc_sva
bind tpc_timer tpc_sva u_sva (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .timer_input_i(timer_input_i),
  .timer_output_pin_o(timer_output_pin_o), .timer_irq_o(timer_irq_o));
`default_nettype wire

// ### verification/tpc_pin_model.sv
// Source for the timer input pin: bursts of level changes on request.
// Assumes burst() is called from a process synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_model (
  input  wire logic mclk_i,
  output logic      pin_o
);
  initial pin_o = 1'b0;
  // Eight clocks per level is far above the synchroniser delay, so no
  // edge can be lost; the pin rests at its last level between bursts.
  task automatic burst(input int n);
    for (int k = 0; k < n; k++) begin
      repeat (8) @(posedge mclk_i);
      pin_o <= ~pin_o;
    end
  endtask : burst
endmodule : tpc_pin_model
`default_nettype wire

// ### verification/tpc_timer_bench.sv
// Self-checking bench for tpc_timer: register rows, then pin scenarios.
// Assumes tpc_pin_model drives the timer input pin.
`timescale 1ns/1ps
`default_nettype none
module tpc_timer_bench;
  import tpc_pkg::*;
  typedef struct packed {logic [11:0] i; logic [7:0] d; logic b;
                         logic [7:0] e;} tpc_row_s;
  localparam tpc_row_s ROWS [10] = '{
    '{12'hF00, 8'h5A, 1'b1, 8'h5A}, '{12'hF00, 8'h77, 1'b0, 8'h5A},
    '{12'hF01, 8'hC3, 1'b1, 8'hC3}, '{12'hF02, 8'h12, 1'b1, 8'h12},
    '{12'hF03, 8'h34, 1'b1, 8'h34}, '{12'hF04, 8'h56, 1'b1, 8'h56},
    '{12'hF05, 8'h78, 1'b1, 8'h78}, '{12'hF06, 8'h45, 1'b1, 8'h45},
    '{12'hF07, 8'hFF, 1'b1, 8'h01}, '{12'hF08, 8'hAB, 1'b1, 8'h00}};
  localparam logic [7:0] RSTV [7] = '{8'h00, 8'h01, 8'hFF, 8'hFF, 8'h00,
                                      8'h00, 8'h00};
  localparam logic [7:0] ECTL [8] = '{8'hC2, 8'h82, 8'h84, 8'hC4, 8'h86,
                                      8'hC6, 8'h87, 8'hC7};
  localparam logic [7:0] EIRQ [8] = '{8'h00, 8'h00, 8'h06, 8'h06, 8'h05,
                                      8'h05, 8'h05, 8'h05};
  logic [13:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0]  ben;
  logic [7:0]  rv;
  logic        mclk, rst_n, ce, rd, wr, wreq, tin, tout, irq, pin_irq;
  int          fail_count, checks_done, n_irq, n_tog;
  tpc_timer dut (.mclk_i(mclk), .rstn_i(rst_n), .ce_i(ce),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(ben), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .timer_input_i(tin),
    .timer_output_pin_o(tout), .timer_irq_o(irq));
  tpc_pin_model u_pin (.mclk_i(mclk), .pin_o(tin));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [11:0] i, input logic w, input logic [7:0] d,
                     input logic b);
    int t;
    @(posedge mclk);
    adr  <= {i, 2'b00};
    wdat <= {24'h0, d};
    ben  <= {3'h0, b};
    rd   <= ~w;
    wr   <= w;
    t = 0;
    @(posedge mclk);
    while (wreq !== 1'b0 && t < 100) begin
      t++;
      @(posedge mclk);
    end
    if (t >= 100) fail_count++;
    rv = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wrr(input logic [11:0] i, input logic [7:0] d);
    bus(i, 1'b1, d, 1'b1);
  endtask : wrr
  task automatic rdc(input logic [11:0] i, input logic [7:0] e);
    bus(i, 1'b0, 8'h00, 1'b1);
    chk(rv, e);
  endtask : rdc
  task automatic meas(input int n);
    logic p;
    p = tout;
    n_irq = 0;
    n_tog = 0;
    repeat (n) begin
      @(posedge mclk);
      if (irq === 1'b1) n_irq++;
      if (irq === 1'b1) pin_irq = tout;
      if (tout !== p) n_tog++;
      p = tout;
    end
  endtask : meas
  task automatic rst_vals;
    for (int k = 0; k < 7; k++) rdc(12'hF00 + k[11:0], RSTV[k]);
    chk({7'h0, tout}, 8'h00);
  endtask : rst_vals
  task automatic test_done;
    $display("checks=%0d errors=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    test_done();
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = '0;
    wdat = '0;
    ben = '0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rst_vals();
    foreach (ROWS[k]) begin
      bus(ROWS[k].i, 1'b1, ROWS[k].d, ROWS[k].b);
      rdc(ROWS[k].i, ROWS[k].e);
    end
    // Continuous and compare modes, reload 3: one reload every 3 clocks.
    for (int m = 1; m <= 5; m += 4) begin
      wrr(12'hF02, 8'h00);
      wrr(12'hF03, 8'h03);
      wrr(12'hF00, 8'h00);
      wrr(12'hF01, 8'h01);
      wrr(12'hF06, 8'h80 | m[7:0]);
      meas(12);
      meas(30);
      chk(n_irq[7:0], 8'h0A);
      chk(n_tog[7:0], 8'h0A);
      ce <= 1'b0;
      meas(20);
      chk(n_irq[7:0], 8'h00);
      ce <= 1'b1;
      wrr(12'hF06, 8'hC0 | m[7:0]);
      wrr(12'hF06, 8'h40 | m[7:0]);
      wrr(12'hF01, 8'h02);
      meas(10);
      chk({7'h0, tout}, 8'h01);
      rdc(12'hF01, 8'h02);
    end
    // PWM, reload 7 and match 3: two pin changes per period.
    wrr(12'hF03, 8'h07);
    wrr(12'hF04, 8'h00);
    wrr(12'hF05, 8'h03);
    for (int p = 0; p < 2; p++) begin
      wrr(12'hF06, {1'b0, p[0], 6'h03});
      meas(4);
      chk({7'h0, tout}, {7'h0, p[0]});
      wrr(12'hF01, 8'h01);
      wrr(12'hF06, {1'b1, p[0], 6'h03});
      meas(14);
      meas(70);
      chk(n_irq[7:0], 8'h0A);
      chk(n_tog[7:0], 8'h14);
      chk({7'h0, pin_irq}, {7'h0, p[0]});
    end
    wrr(12'hF06, 8'h00);
    wrr(12'hF03, 8'h03);
    wrr(12'hF01, 8'h01);
    wrr(12'hF06, 8'h80);
    meas(30);
    chk(n_irq[7:0], 8'h01);
    rdc(12'hF06, 8'h00);
    // Input-driven modes; the pin level alternates from row to row.
    wrr(12'hF02, 8'hFF);
    wrr(12'hF03, 8'hFF);
    foreach (ECTL[k]) begin
      wrr(12'hF06, ECTL[k] & 8'h7F);
      wrr(12'hF01, 8'h01);
      wrr(12'hF06, ECTL[k]);
      fork
        u_pin.burst(11);
        meas(100);
      join
      chk(n_irq[7:0], EIRQ[k]);
      if (ECTL[k][2:0] == 3'h2) rdc(12'hF01, 8'h06);
      if (ECTL[k][2:0] == 3'h7) rdc(12'hF07, {7'h01, ECTL[k][6]});
    end
    wrr(12'hF06, 8'h81);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rst_vals();
    test_done();
  end
endmodule : tpc_timer_bench
`default_nettype wire
